// [verilog/tcc_core.v]
// Purpose: Counter and single output-compare core of an 8-bit timer
// Assumes: CPU strobes are one-cycle pulses on core_clk; no register bus
// Notes: Flag and mask bits are plain ports; global enable is an input
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

// Contract
// - Counter and compare value are 8-bit, CPU readable and writable.
// - Source select zero gives no tick; counter holds.
// - Tick from 10-bit prescaler or count pin, source and edge chosen.
// - Bottom indication when the counter equals 0x00.
// - Max indication when the counter reaches 0xFF.
// - Top is 0xFF or compare value, chosen by mode.
// - Each tick clears, increments or decrements the counter per mode.
// - Clear sets every counter bit to zero.
// - CPU counter access works with or without a tick source.
// - CPU counter write beats a coinciding clear or count.
// - Two waveform mode bits select the counting sequence.
// - Overflow flag set at the mode's point; usable as interrupt.
// - Comparator continuously flags counter equal to active compare value.
// - Match sets the compare flag on the following tick.
// - Compare interrupt needs flag, enable bit and global enable.
// - Compare flag clears when its interrupt is serviced.
// - Writing one to the compare flag bit clears it.
// - Waveform generator drives output from match, mode and action bits.
// - Max and bottom go to the waveform generator for extremes.
// - PWM modes buffer compare writes; other modes write directly.
// - Buffered value moves to active compare only at top or bottom.
// - Flags readable in shared flag register, each with own mask; here each flag is its own output port.
// - Counter write blocks compare matches during the following tick.
module tcc_core (
  input wire core_clk,
  input wire sys_rst,
  input wire [2:0] clock_source_select,
  input wire [1:0] waveform_mode_select,
  input wire [1:0] compare_output_action,
  input wire external_count_pin,
  input wire cnt_wr,
  input wire [7:0] cnt_wdata,
  input wire cmp_wr,
  input wire [7:0] cmp_wdata,
  input wire flag_wr,
  input wire flag_wr_compare,
  input wire flag_wr_overflow,
  input wire compare_irq_enable,
  input wire overflow_irq_enable,
  input wire global_irq_enable,
  input wire compare_irq_ack,
  input wire overflow_irq_ack,
  output reg [7:0] counter_value,
  output reg [7:0] compare_value,
  output reg compare_flag,
  output reg overflow_flag,
  output reg compare_irq,
  output reg overflow_irq,
  output reg bottom_out,
  output reg max_out,
  output wire compare_output_pin
);

  wire timer_tick;
  reg [7:0] cmp_act_q;
  reg [7:0] cmp_buf_q;
  reg dir_down_q;
  reg block_q;
  reg [7:0] cnt_d;
  reg dir_down_d;
  reg ovf_ev;
  reg upd_ev;
  wire is_pwm;
  wire is_pc;
  wire [7:0] top_val;
  wire at_top;
  wire at_bottom;
  wire match;
  wire match_ev;
  wire cmp_set;
  wire ovf_set;

  // Add or subtract one without width growth
  function [7:0] step8;
    input [7:0] v;
    input down;
    begin
      step8 = down ? v - `TCC_ONE : v + `TCC_ONE;
    end
  endfunction

  tcc_tick_sel u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clock_source_select(clock_source_select),
    .external_count_pin(external_count_pin),
    .timer_tick(timer_tick)
  );

  // Mode decode and extreme values
  assign is_pwm = waveform_mode_select[0];
  assign is_pc = (waveform_mode_select == `TCC_WGM_PC_PWM);
  assign top_val = (waveform_mode_select == `TCC_WGM_CTC) ? cmp_act_q : `TCC_MAX;
  assign at_top = (counter_value == top_val);
  assign at_bottom = (counter_value == `TCC_BOTTOM);
  assign match = (counter_value == cmp_act_q);
  // A match right after a counter write is ignored for that tick
  assign match_ev = timer_tick && match && !block_q;

  // Count sequence per mode; a CPU write overrides the tick
  always @*
  begin
    cnt_d = counter_value;
    dir_down_d = dir_down_q;
    ovf_ev = 1'b0;
    upd_ev = 1'b0;
    if (cnt_wr)
      cnt_d = cnt_wdata;
    if (timer_tick)
    begin
      case (waveform_mode_select)
        `TCC_WGM_NORMAL:
        begin
          ovf_ev = (counter_value == `TCC_MAX);
          if (!cnt_wr)
            cnt_d = step8(counter_value, 1'b0);
        end
        `TCC_WGM_CTC:
        begin
          ovf_ev = (counter_value == `TCC_MAX);
          if (!cnt_wr)
            cnt_d = at_top ? `TCC_BOTTOM : step8(counter_value, 1'b0);
        end
        `TCC_WGM_FAST_PWM:
        begin
          ovf_ev = at_top;
          upd_ev = at_top;
          if (!cnt_wr)
            cnt_d = at_top ? `TCC_BOTTOM : step8(counter_value, 1'b0);
        end
        `TCC_WGM_PC_PWM:
        begin
          // Turn at top and bottom; compare reload at top, overflow at bottom
          ovf_ev = at_bottom && dir_down_q;
          upd_ev = at_top && !dir_down_q;
          if (at_top)
            dir_down_d = 1'b1;
          else if (at_bottom)
            dir_down_d = 1'b0;
          if (!cnt_wr)
            cnt_d = step8(counter_value, dir_down_d);
        end
        default: cnt_d = counter_value;
      endcase
    end
    if (!is_pc)
      dir_down_d = 1'b0;
  end

  // Counter, direction and write-blocking state
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      counter_value <= `TCC_CNT_RST;
      dir_down_q <= 1'b0;
      block_q <= 1'b0;
    end
    else
    begin
      counter_value <= cnt_d;
      dir_down_q <= dir_down_d;
      // Held until a tick passes, so a stopped timer still blocks one tick
      if (cnt_wr)
        block_q <= 1'b1;
      else if (timer_tick)
        block_q <= 1'b0;
    end
  end

  // Compare value: buffer in PWM modes, direct otherwise
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cmp_act_q <= `TCC_CMP_RST;
      cmp_buf_q <= `TCC_CMP_RST;
    end
    else
    begin
      if (cmp_wr)
        cmp_buf_q <= cmp_wdata;
      if (cmp_wr && !is_pwm)
        cmp_act_q <= cmp_wdata;
      else if (is_pwm && upd_ev)
        cmp_act_q <= cmp_buf_q;
    end
  end

  // CPU reads the last written value, the same as the buffer, in every mode
  always @(posedge core_clk)
  begin
    if (sys_rst)
      compare_value <= `TCC_CMP_RST;
    else if (cmp_wr)
      compare_value <= cmp_wdata;
  end

  // Flags: hardware set wins over a clear in the same cycle
  assign cmp_set = match_ev;
  assign ovf_set = ovf_ev;

  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      compare_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end
    else
    begin
      if (cmp_set)
        compare_flag <= 1'b1;
      else if ((flag_wr && flag_wr_compare) || compare_irq_ack)
        compare_flag <= 1'b0;
      if (ovf_set)
        overflow_flag <= 1'b1;
      else if ((flag_wr && flag_wr_overflow) || overflow_irq_ack)
        overflow_flag <= 1'b0;
    end
  end

  // Interrupt requests follow flags one cycle later, gated by own masks
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      compare_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end
    else
    begin
      compare_irq <= compare_flag && compare_irq_enable && global_irq_enable;
      overflow_irq <= overflow_flag && overflow_irq_enable && global_irq_enable;
    end
  end

  // Registered extreme indications
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      bottom_out <= 1'b1;
      max_out <= 1'b0;
    end
    else
    begin
      bottom_out <= (cnt_d == `TCC_BOTTOM);
      max_out <= (cnt_d == `TCC_MAX);
    end
  end

  tcc_wave_gen u_wave (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .waveform_mode_select(waveform_mode_select),
    .compare_output_action(compare_output_action),
    .match_ev(match_ev),
    .max_ev(timer_tick && (counter_value == `TCC_MAX)),
    .bottom_ev(timer_tick && at_bottom),
    .cmp_is_max(cmp_act_q == `TCC_MAX),
    .cmp_is_bottom(cmp_act_q == `TCC_BOTTOM),
    .count_down(dir_down_q),
    .compare_output_pin(compare_output_pin)
  );

endmodule // tcc_core

`default_nettype wire

// [pkg/tcc_defs.vh]
// Purpose: Shared constants for the 8-bit timer compare core
// Assumes: Included by bare name from every design file
// Notes: Mode codes follow the two waveform mode select bits
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

`define TCC_BOTTOM 8'h00
`define TCC_MAX 8'hFF
`define TCC_ONE 8'h01
`define TCC_CNT_RST 8'h00
`define TCC_CMP_RST 8'h00

// Clock source select codes
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_CS_EXT_FALL 3'h6
`define TCC_CS_EXT_RISE 3'h7

// Prescaler taps
`define TCC_PRE_W 10
`define TCC_PRE_ZERO 10'h000
`define TCC_PRE_ONE 10'h001
`define TCC_TAP8 3'h7
`define TCC_TAP64 6'h3F
`define TCC_TAP256 8'hFF
`define TCC_TAP1024 10'h3FF

// Waveform modes
`define TCC_WGM_NORMAL 2'h0
`define TCC_WGM_PC_PWM 2'h1
`define TCC_WGM_CTC 2'h2
`define TCC_WGM_FAST_PWM 2'h3

// Compare output actions
`define TCC_COM_NONE 2'h0
`define TCC_COM_TOGGLE 2'h1
`define TCC_COM_CLEAR 2'h2
`define TCC_COM_SET 2'h3

`endif

// [verilog/tcc_tick_sel.v]
// Purpose: Timer tick selection from a 10-bit prescaler or the count pin
// Assumes: core_clk at 50 MHz, count pin asynchronous
// Notes: Tick is a one-cycle enable; no tick when source select is zero
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_tick_sel (
  input wire core_clk,
  input wire sys_rst,
  input wire [2:0] clock_source_select,
  input wire external_count_pin,
  output reg timer_tick
);

  reg [9:0] pre_q;
  reg sync1_q;
  reg sync2_q;
  reg sync3_q;
  reg pin_q;
  reg tick_d;

  // Free-running prescaler; runs only while a source is chosen to save power
  always @(posedge core_clk)
  begin
    if (sys_rst || clock_source_select == `TCC_CS_STOP)
      pre_q <= `TCC_PRE_ZERO;
    else
      pre_q <= pre_q + `TCC_PRE_ONE;
  end

  // Three stages; a change counts only when stages two and three agree
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      pin_q <= 1'b0;
    end
    else
    begin
      sync1_q <= external_count_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q)
        pin_q <= sync3_q;
    end
  end

  // Source and edge choice
  always @*
  begin
    case (clock_source_select)
      `TCC_CS_STOP: tick_d = 1'b0;
      `TCC_CS_DIV1: tick_d = 1'b1;
      `TCC_CS_DIV8: tick_d = (pre_q[2:0] == `TCC_TAP8);
      `TCC_CS_DIV64: tick_d = (pre_q[5:0] == `TCC_TAP64);
      `TCC_CS_DIV256: tick_d = (pre_q[7:0] == `TCC_TAP256);
      `TCC_CS_DIV1024: tick_d = (pre_q == `TCC_TAP1024);
      `TCC_CS_EXT_FALL: tick_d = pin_q && (sync2_q == sync3_q) && !sync3_q;
      `TCC_CS_EXT_RISE: tick_d = !pin_q && (sync2_q == sync3_q) && sync3_q;
      default: tick_d = 1'b0;
    endcase
  end

  // Registered tick keeps the enable glitch-free
  always @(posedge core_clk)
  begin
    if (sys_rst)
      timer_tick <= 1'b0;
    else
      timer_tick <= tick_d;
  end

endmodule // tcc_tick_sel

`default_nettype wire

// [verilog/tcc_wave_gen.v]
// Purpose: Compare output waveform generator
// Assumes: Match, max and bottom qualified by the tick in the core
// Notes: Output register resets low
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.vh"

module tcc_wave_gen (
  input wire core_clk,
  input wire sys_rst,
  input wire [1:0] waveform_mode_select,
  input wire [1:0] compare_output_action,
  input wire match_ev,
  input wire max_ev,
  input wire bottom_ev,
  input wire cmp_is_max,
  input wire cmp_is_bottom,
  input wire count_down,
  output reg compare_output_pin
);

  reg oc_d;

  // Next output level from the mode, action and extreme-value events
  always @*
  begin
    oc_d = compare_output_pin;
    case (waveform_mode_select)
      `TCC_WGM_NORMAL, `TCC_WGM_CTC:
      begin
        if (match_ev)
        begin
          if (compare_output_action == `TCC_COM_TOGGLE)
            oc_d = !compare_output_pin;
          else if (compare_output_action == `TCC_COM_CLEAR)
            oc_d = 1'b0;
          else if (compare_output_action == `TCC_COM_SET)
            oc_d = 1'b1;
        end
      end
      `TCC_WGM_FAST_PWM:
      begin
        if (compare_output_action[1])
        begin
          // Match wins when the compare value sits at max, so no spike
          if (match_ev)
            oc_d = compare_output_action[0];
          else if (max_ev)
            oc_d = !compare_output_action[0];
        end
      end
      `TCC_WGM_PC_PWM:
      begin
        if (compare_output_action[1])
        begin
          if (match_ev)
            oc_d = compare_output_action[0] ^ count_down;
          else if (max_ev && cmp_is_max)
            oc_d = compare_output_action[0] ^ 1'b1;
          else if (bottom_ev && cmp_is_bottom)
            oc_d = compare_output_action[0];
        end
      end
      default: oc_d = compare_output_pin;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
      compare_output_pin <= 1'b0;
    else
      compare_output_pin <= oc_d;
  end

endmodule // tcc_wave_gen

`default_nettype wire

// [tb/tcc_core_checker.sv]
// Purpose: Port assertions for the 8-bit timer compare core
// Assumes: One clock domain, sys_rst synchronous active high
// Notes: The tick is internal, so held source settings stand in for it
`timescale 1ns/1ps
`default_nettype none
module tcc_core_checker (
  input wire core_clk,
  input wire sys_rst,
  input wire [2:0] clock_source_select,
  input wire [1:0] waveform_mode_select,
  input wire cnt_wr,
  input wire [7:0] cnt_wdata,
  input wire cmp_wr,
  input wire [7:0] cmp_wdata,
  input wire flag_wr,
  input wire flag_wr_compare,
  input wire compare_irq_enable,
  input wire global_irq_enable,
  input wire compare_irq_ack,
  input wire [7:0] counter_value,
  input wire [7:0] compare_value,
  input wire compare_flag,
  input wire overflow_flag,
  input wire compare_irq,
  input wire bottom_out,
  input wire max_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Undivided source held long enough that every cycle is a tick
  sequence s_run;
    (clock_source_select == 3'h1 && waveform_mode_select == 2'h0 && !cnt_wr) [*4];
  endsequence
  // Stopped long enough that no tick is still in flight
  sequence s_idle;
    (clock_source_select == 3'h0 && !cnt_wr) [*2];
  endsequence
  chk_bottom_ind: assert property (bottom_out == (counter_value == 8'h00))
    else $error("bottom indication wrong");
  chk_max_ind: assert property (max_out == (counter_value == 8'hFF))
    else $error("max indication wrong");
  chk_stop_hold: assert property (s_idle |=> $stable(counter_value))
    else $error("counter moved while stopped");
  chk_write_wins: assert property (cnt_wr |=> counter_value == $past(cnt_wdata))
    else $error("counter write lost");
  chk_cmp_write: assert property (cmp_wr |=> compare_value == $past(cmp_wdata))
    else $error("compare write lost");
  chk_step_size: assert property (!cnt_wr |=> counter_value == 8'h00
    || (counter_value - $past(counter_value)) inside {8'h00, 8'h01, 8'hFF})
    else $error("counter step illegal");
  chk_flag_clear: assert property (s_idle ##0 (compare_irq_ack
    || (flag_wr && flag_wr_compare)) |=> !compare_flag)
    else $error("compare flag not cleared");
  chk_irq_gate: assert property (1'b1 |=> compare_irq
    == $past(compare_flag && compare_irq_enable && global_irq_enable))
    else $error("compare request gating wrong");
  chk_ovf_set: assert property (s_run ##0 counter_value == 8'hFF |=> overflow_flag)
    else $error("overflow flag missed");
  chk_match_set: assert property (s_run ##0 counter_value == compare_value
    |=> compare_flag)
    else $error("compare flag missed");
endmodule // tcc_core_checker
bind tcc_core tcc_core_checker i_chk (.*);
`default_nettype wire

// [tb/tcc_pin_partner.sv]
// Purpose: Far side model driving the count pin and watching the output pin
// Assumes: Pulses are slow against core_clk
// Notes: The count pin idles low between bursts
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_partner (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic compare_output_pin,
  output logic external_count_pin,
  output logic done,
  output logic [7:0] pin_rises
);
  initial
  begin
    external_count_pin = 1'b0;
    done = 1'b1;
    pin_rises = 8'h00;
  end
  // Eight cycles per level so the synchroniser never misses an edge
  always @(posedge go)
  begin
    done = 1'b0;
    repeat (n_pulses)
    begin
      repeat (8) @(posedge core_clk);
      external_count_pin <= 1'b1;
      repeat (8) @(posedge core_clk);
      external_count_pin <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    done = 1'b1;
  end
  // Rising output edges, two matches per rise when toggling
  always @(posedge compare_output_pin)
    pin_rises <= pin_rises + 8'h01;
endmodule // tcc_pin_partner
`default_nettype wire

// [tb/tcc_core_tb.sv]
// Purpose: Self-checking bench for the 8-bit timer compare core
// Assumes: Inputs change on the falling edge of core_clk
// Notes: Random data from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module tcc_core_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] clock_source_select = 3'h0;
  logic [1:0] waveform_mode_select = 2'h0;
  logic [1:0] compare_output_action = 2'h1;
  logic cnt_wr = 1'b0, cmp_wr = 1'b0, flag_wr = 1'b0, go = 1'b0;
  logic flag_wr_compare = 1'b0, flag_wr_overflow = 1'b0;
  logic compare_irq_enable = 1'b1, overflow_irq_enable = 1'b1, global_irq_enable = 1'b1;
  logic compare_irq_ack = 1'b0, overflow_irq_ack = 1'b0;
  logic [7:0] cnt_wdata = 8'h00, cmp_wdata = 8'h00, n_pulses = 8'h00;
  logic [7:0] counter_value, compare_value, pin_rises, top_seen, r0, last;
  logic compare_flag, overflow_flag, compare_irq, overflow_irq;
  logic bottom_out, max_out, compare_output_pin, external_count_pin, done;
  logic [31:0] seed = 32'hC05C4BE4;
  int fail_count = 0;
  int n_tests = 0;
  tcc_core i_dut (.*);
  tcc_pin_partner i_pin (.*);
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Counting top depends on the mode
  function automatic logic [7:0] exp_top(input logic [1:0] m);
    return (m == 2'h2) ? 8'h30 : 8'hFF;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr_cnt(input logic [7:0] v);
    cnt_wdata = v;
    cnt_wr = 1'b1;
    cyc(1);
    cnt_wr = 1'b0;
  endtask
  task automatic wr_cmp(input logic [7:0] v);
    cmp_wdata = v;
    cmp_wr = 1'b1;
    cyc(1);
    cmp_wr = 1'b0;
  endtask
  task automatic wr_flags(input logic c, input logic o);
    flag_wr_compare = c;
    flag_wr_overflow = o;
    flag_wr = 1'b1;
    cyc(1);
    flag_wr = 1'b0;
    cyc(1);
  endtask
  // Main sequence, each wait bounded
  initial
  begin
    cyc(10);
    sys_rst = 1'b0;
    cyc(1);
    check({bottom_out, max_out, compare_flag, overflow_flag}, 8'h08);
    repeat (16)
    begin
      seed = lfsr(seed);
      wr_cnt(seed[7:0]);
      wr_cmp(seed[15:8]);
      check(counter_value, seed[7:0]);
      check(compare_value, seed[15:8]);
    end
    wr_cnt(8'hFF);
    check(max_out, 1'b1);
    last = counter_value;
    cyc(20);
    check(counter_value, last);
    // A write equal to the compare value must not raise the flag
    wr_cmp(8'h40);
    wr_cnt(8'h40);
    wr_flags(1'b1, 1'b1);
    clock_source_select = 3'h1;
    cyc(6);
    clock_source_select = 3'h0;
    cyc(2);
    check(compare_flag, 1'b0);
    wr_cmp(8'hF8);
    clock_source_select = 3'h1;
    cyc(3);
    wr_cnt(8'hF0);
    check(counter_value, 8'hF0);
    for (int i = 0; i < 40 && overflow_flag !== 1'b1; i++)
      cyc(1);
    if (overflow_flag !== 1'b1)
      fail_count++;
    cyc(2);
    check({compare_flag, compare_irq, overflow_irq}, 8'h07);
    check(counter_value < 8'h10, 1'b1);
    clock_source_select = 3'h0;
    global_irq_enable = 1'b0;
    cyc(2);
    check(compare_irq, 1'b0);
    global_irq_enable = 1'b1;
    compare_irq_ack = 1'b1;
    cyc(1);
    compare_irq_ack = 1'b0;
    cyc(1);
    check(compare_flag, 1'b0);
    wr_flags(1'b0, 1'b1);
    check(overflow_flag, 1'b0);
    // Every waveform mode, tracking the highest count reached
    r0 = pin_rises;
    for (int m = 0; m < 4; m++)
    begin
      clock_source_select = 3'h0;
      waveform_mode_select = m[1:0];
      wr_cmp(m == 2 ? 8'h30 : 8'h80);
      wr_cnt(8'h00);
      wr_flags(1'b1, 1'b1);
      top_seen = 8'h00;
      clock_source_select = 3'h1;
      repeat (600)
      begin
        cyc(1);
        if (counter_value > top_seen)
          top_seen = counter_value;
      end
      check(top_seen, exp_top(m[1:0]));
      check(compare_flag, 1'b1);
      check(overflow_flag, m != 2);
    end
    check(pin_rises != r0, 1'b1);
    // Fast PWM: a new compare value waits in the buffer until the top
    clock_source_select = 3'h0;
    wr_cmp(8'h10);
    wr_cnt(8'h0E);
    wr_flags(1'b1, 1'b1);
    clock_source_select = 3'h1;
    cyc(6);
    clock_source_select = 3'h0;
    cyc(2);
    check(compare_flag, 1'b0);
    check(compare_value, 8'h10);
    // Count pin, rising then falling edges
    waveform_mode_select = 2'h0;
    for (int k = 0; k < 2; k++)
    begin
      clock_source_select = 3'h0;
      wr_cnt(8'h00);
      seed = lfsr(seed);
      n_pulses = {5'h00, seed[2:0]} + 8'h01;
      clock_source_select = k ? 3'h6 : 3'h7;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      for (int i = 0; i < 400 && done !== 1'b1; i++)
        cyc(1);
      if (done !== 1'b1)
        fail_count++;
      cyc(8);
      check(counter_value, n_pulses);
    end
    wrap_up;
  end
endmodule // tcc_core_tb
`default_nettype wire
